// ==== fan_drive_ramp_control.sv ====
// fan drive ramp control: enhanced acoustics register 1 and its effects on the drives
// assumes a serial bus front end supplies byte writes/reads with a register address
//
// What this block does
// - enabled ramping steps fan_drive_1 gradually toward target
// - rate codes give steps 1,2,3,4,8,12,24,48
// - ramp_enable_1 set turns ramping on
// - align set times speed inputs 2,3,4
// - align clear times speed inputs 3,4 only
// - fan_drive_1 below threshold in auto mode: off or minimum
// - fan_drive_2 below threshold in auto mode: off or minimum
// - fan_drive_3 below threshold in auto mode: off or minimum
// - register resets to all zeros
// - cfg_lock input, not a register bit, blocks further writes until reset
`default_nettype none
module fan_drive_ramp_control #(
	parameter int slot_len = fan_acoustics_pkg::slot_cycles // cycles per ramp time slot
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// register access from the serial bus front end
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       cfg_lock,
	// automatic control loop inputs
	input  wire logic       auto_mode,
	input  wire logic [2:0] below_low,
	input  wire logic [7:0] calc_duty_1,
	input  wire logic [7:0] calc_duty_2,
	input  wire logic [7:0] calc_duty_3,
	input  wire logic [7:0] min_duty_1,
	input  wire logic [7:0] min_duty_2,
	input  wire logic [7:0] min_duty_3,
	// drive outputs
	output logic      [7:0] fan_drive_1,
	output logic      [7:0] fan_drive_2,
	output logic      [7:0] fan_drive_3,
	// speed inputs timed to fan_drive_3
	output logic      [3:0] speed_align
);
	typedef enum logic [1:0] {
		st_idle = 2'b01, // waiting for a write
		st_lock = 2'b10  // register frozen
	} wr_state_e;

	wr_state_e                   state_reg;    // write gate state
	wr_state_e                   state_next;
	logic                  [7:0] cfg_reg;      // enhanced_acoustics_cfg_1
	logic                  [7:0] cfg_next;
	fan_acoustics_pkg::cfg_s     cfg;          // decoded fields
	logic                        hit;          // address match
	logic                        wr_ok;        // write accepted
	logic                  [7:0] rdata_reg;    // read data latch
	logic                 [31:0] slot_cnt_reg; // time slot counter
	logic                        slot_tick;    // one-cycle slot pulse
	logic                  [7:0] tgt_1;        // floor-adjusted targets
	logic                  [7:0] tgt_2;
	logic                  [7:0] tgt_3;
	logic                  [7:0] ramped_1;     // ramp stage output
	logic                  [7:0] drv1_reg;
	logic                  [7:0] drv2_reg;
	logic                  [7:0] drv3_reg;
	logic                  [3:0] align_reg;

	assign cfg = fan_acoustics_pkg::cfg_s'(cfg_reg);
	assign hit = (reg_addr == fan_acoustics_pkg::cfg_offset);
	assign wr_ok = reg_wr && hit && (state_reg == st_idle) && !cfg_lock;

	// lock is sticky until reset, even after the cfg_lock input that sets it falls
	always_comb begin
		case (state_reg)
			st_idle: state_next = cfg_lock ? st_lock : st_idle;
			st_lock: state_next = st_lock;
			default: state_next = st_idle;
		endcase
	end

	assign cfg_next = wr_ok ? reg_wdata : cfg_reg;

	// register and write gate
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg   <= fan_acoustics_pkg::cfg_reset;
			state_reg <= st_idle;
		end else begin
			cfg_reg   <= cfg_next;
			state_reg <= state_next;
		end
	end

	// read data, held between reads; unmapped addresses read zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rdata_reg <= 8'h00;
		else if (reg_rd)
			rdata_reg <= hit ? cfg_reg : 8'h00;
	end
	assign reg_rdata = rdata_reg;

	// time slot counter paces the ramp
	assign slot_tick = (slot_cnt_reg == 32'(slot_len - 1));
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			slot_cnt_reg <= 32'h0;
		else
			slot_cnt_reg <= slot_tick ? 32'h0 : slot_cnt_reg + 32'h1;
	end

	// below the low threshold in auto mode: floor select picks off or minimum
	assign tgt_1 = (auto_mode && below_low[0])
		? (cfg.floor_sel_1 ? min_duty_1 : fan_acoustics_pkg::duty_off)
		: calc_duty_1;
	assign tgt_2 = (auto_mode && below_low[1])
		? (cfg.floor_sel_2 ? min_duty_2 : fan_acoustics_pkg::duty_off)
		: calc_duty_2;
	assign tgt_3 = (auto_mode && below_low[2])
		? (cfg.floor_sel_3 ? min_duty_3 : fan_acoustics_pkg::duty_off)
		: calc_duty_3;

	// only drive 1 ramps here; drives 2 and 3 take their floor-adjusted targets with no ramp
	duty_ramp u_ramp_1 (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ramp_on   (cfg.ramp_enable_1),
		.slot_tick (slot_tick),
		.step      (fan_acoustics_pkg::ramp_step(cfg.ramp_rate_1)),
		.target    (tgt_1),
		.duty      (ramped_1)
	);

	// registered outputs; bit n of speed_align is speed input n+1
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			drv1_reg  <= 8'h00;
			drv2_reg  <= 8'h00;
			drv3_reg  <= 8'h00;
			align_reg <= 4'h0;
		end else begin
			drv1_reg  <= ramped_1;
			drv2_reg  <= tgt_2;
			drv3_reg  <= tgt_3;
			align_reg <= {2'b11, cfg.tach_align_all, 1'b0};
		end
	end

	assign fan_drive_1 = drv1_reg;
	assign fan_drive_2 = drv2_reg;
	assign fan_drive_3 = drv3_reg;
	assign speed_align = align_reg;
endmodule
`default_nettype wire

// ==== fan_acoustics_pkg.sv ====
// package for the fan drive ramp control block: register map, field layout, ramp steps
// assumes an 8-bit duty scale where 0xff is full drive
`default_nettype none
package fan_acoustics_pkg;
	localparam logic [7:0] cfg_offset       = 8'h62; // enhanced_acoustics_cfg_1 address
	localparam logic [7:0] cfg_reset        = 8'h00; // power-on value
	localparam int         ramp_rate_lsb    = 0;     // ramp_rate_1 <2:0>
	localparam int         ramp_enable_bit  = 3;     // ramp_enable_1
	localparam int         tach_align_bit   = 4;     // tach_phase_align_all
	localparam int         floor_sel_1_bit  = 5;     // floor_select_1
	localparam int         floor_sel_2_bit  = 6;     // floor_select_2
	localparam int         floor_sel_3_bit  = 7;     // floor_select_3
	localparam logic [7:0] duty_off         = 8'h00; // 0% duty
	// time slot length between ramp steps, in ms, and in cycles at 100 MHz
	localparam int         slot_time_ms     = 1;
	localparam int         clk_mhz          = 100;
	localparam int         slot_cycles      = slot_time_ms * clk_mhz * 1000;

	// ramp step size per time slot for codes 000..111
	function automatic logic [7:0] ramp_step(input logic [2:0] code);
		case (code)
			3'h0: ramp_step = 8'h01;
			3'h1: ramp_step = 8'h02;
			3'h2: ramp_step = 8'h03;
			3'h3: ramp_step = 8'h04;
			3'h4: ramp_step = 8'h08;
			3'h5: ramp_step = 8'h0c;
			3'h6: ramp_step = 8'h18;
			default: ramp_step = 8'h30;
		endcase
	endfunction

	// decoded register fields travelling together
	typedef struct packed {
		logic       floor_sel_3;
		logic       floor_sel_2;
		logic       floor_sel_1;
		logic       tach_align_all;
		logic       ramp_enable_1;
		logic [2:0] ramp_rate_1;
	} cfg_s;
endpackage
`default_nettype wire

// ==== duty_ramp.sv ====
// one duty ramp stage: moves its output toward a target by a step per slot
// assumes slot_tick is a one-cycle pulse in the clk_sys domain
`default_nettype none
module duty_ramp (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// control
	input  wire logic       ramp_on,
	input  wire logic       slot_tick,
	input  wire logic [7:0] step,
	input  wire logic [7:0] target,
	// result
	output logic      [7:0] duty
);
	logic [7:0] duty_reg;   // current applied duty
	logic [7:0] duty_next;  // next applied duty
	logic [8:0] up_sum;     // headroom-safe sum
	logic [7:0] gap_up;     // distance when rising
	logic [7:0] gap_dn;     // distance when falling

	assign gap_up = target - duty_reg;
	assign gap_dn = duty_reg - target;
	assign up_sum = {1'b0, duty_reg} + {1'b0, step};

	// clamp at target so a large step never overshoots
	always_comb begin
		duty_next = duty_reg;
		if (!ramp_on) begin
			duty_next = target;
		end else if (slot_tick) begin
			if (target > duty_reg)
				duty_next = (gap_up <= step) ? target : up_sum[7:0];
			else if (target < duty_reg)
				duty_next = (gap_dn <= step) ? target : duty_reg - step;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			duty_reg <= 8'h00;
		else
			duty_reg <= duty_next;
	end

	assign duty = duty_reg;
endmodule
`default_nettype wire

// ==== fan_ctrl_checker.sv ====
// port assertions for the fan drive ramp control block
// assumes one clock domain; bound to every instance of the block below
`default_nettype none
module fan_ctrl_checker (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// register side
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       cfg_lock,
	// control loop and drives
	input wire logic       auto_mode,
	input wire logic [2:0] below_low,
	input wire logic [7:0] calc_duty_2,
	input wire logic [7:0] calc_duty_3,
	input wire logic [7:0] min_duty_2,
	input wire logic [7:0] min_duty_3,
	input wire logic [7:0] fan_drive_2,
	input wire logic [7:0] fan_drive_3,
	input wire logic [3:0] speed_align
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic       lock_seen_reg; // lock seen since reset, as the block keeps it
	logic [7:0] cfg_copy_reg;  // config as last accepted from the host
	logic       wr_open;       // a write the block must take
	logic       align_all;     // expected speed input 2 alignment
	logic [7:0] floor_2;       // expected drive 2 below threshold
	logic [7:0] floor_3;       // expected drive 3 below threshold
	assign wr_open   = reg_wr && reg_addr == 8'h62 && !cfg_lock && !lock_seen_reg;
	assign align_all = cfg_copy_reg[4];
	assign floor_2   = cfg_copy_reg[6] ? min_duty_2 : 8'h00;
	assign floor_3   = cfg_copy_reg[7] ? min_duty_3 : 8'h00;
	// shadow of the register; the lock input may fall, the lock itself may not
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_seen_reg <= 1'b0;
			cfg_copy_reg  <= 8'h00;
		end else begin
			lock_seen_reg <= lock_seen_reg | cfg_lock;
			if (wr_open) begin
				cfg_copy_reg <= reg_wdata;
			end
		end
	end
	// a config write with the config read right behind it
	sequence wr_hit; wr_open; endsequence
	sequence rd_hit; reg_rd && reg_addr == 8'h62; endsequence
	chk_write_readback: assert property (
		wr_hit ##1 rd_hit |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
	chk_unmapped_zero: assert property (
		reg_rd && reg_addr != 8'h62 |=> reg_rdata == 8'h00) else $error("unmapped read");
	chk_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
	chk_align_fixed: assert property (
		$past(rst_n) |-> speed_align == {2'b11, $past(align_all), 1'b0}) else $error("align");
	chk_drive2_calc: assert property (
		!(auto_mode && below_low[1]) |=> fan_drive_2 == $past(calc_duty_2)) else $error("drive 2");
	chk_drive3_calc: assert property (
		!(auto_mode && below_low[2]) |=> fan_drive_3 == $past(calc_duty_3)) else $error("drive 3");
	chk_drive2_floor: assert property (
		auto_mode && below_low[1] |=> fan_drive_2 == $past(floor_2)) else $error("floor 2");
	chk_drive3_floor: assert property (
		auto_mode && below_low[2] |=> fan_drive_3 == $past(floor_3)) else $error("floor 3");
endmodule
bind fan_drive_ramp_control fan_ctrl_checker u_chk (.clk_sys, .rst_n, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rd, .reg_rdata, .cfg_lock, .auto_mode, .below_low, .calc_duty_2,
	.calc_duty_3, .min_duty_2, .min_duty_3, .fan_drive_2, .fan_drive_3, .speed_align);
`default_nettype wire

// ==== fan_host.sv ====
// host model: single byte register writes and reads
// assumes callers enter its tasks just after a rising edge
`default_nettype none
module fan_host (
	// clock and read data
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	// requests
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
	// held over one edge; data scrambled after so a stale byte is never seen
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk_sys);
		#1 {reg_wr, reg_wdata} = {1'b0, ~d};
	endtask
	// read data is registered, settled one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ==== fan_drive_ramp_control_tb.sv ====
// self-checking bench for fan drive ramp control
// assumes the host model owns the register side
`default_nettype none
module fan_drive_ramp_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0, rst_n = 1'b0, cfg_lock = 1'b0, auto_mode = 1'b0;
	logic [2:0] below_low = 3'h0;
	logic [7:0] calc_duty_1 = 8'h00, calc_duty_2 = 8'h27, calc_duty_3 = 8'h3c;
	logic [7:0] min_duty_1 = 8'h15, min_duty_2 = 8'h25, min_duty_3 = 8'h35, rd_val;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fan_drive_1, fan_drive_2, fan_drive_3;
	logic       reg_wr, reg_rd;
	logic [3:0] speed_align;
	int         mismatches = 0, n_checks = 0, cycles = 0;
	always #5 clk_sys = ~clk_sys;
	fan_drive_ramp_control #(.slot_len(4)) u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .cfg_lock, .auto_mode, .below_low, .calc_duty_1,
		.calc_duty_2, .calc_duty_3, .min_duty_1, .min_duty_2, .min_duty_3, .fan_drive_1,
		.fan_drive_2, .fan_drive_3, .speed_align);
	fan_host u_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// power-on value, then the align bit and a back-to-back readback
	task automatic t_reg;
		u_host.rd(8'h62, rd_val);
		chk(rd_val, 8'h00);
		chk({4'h0, speed_align}, 8'h0c);
		u_host.wr(8'h62, 8'h10);
		u_host.rd(8'h62, rd_val);
		chk(rd_val, 8'h10);
		tick(1);
		chk({4'h0, speed_align}, 8'h0e);
		$display("register test done");
	endtask
	// floors per drive, then off, then manual mode ignores below_low
	task automatic t_floor;
		u_host.wr(8'h62, 8'he0);
		{auto_mode, below_low} = 4'hf;
		tick(3);
		chk(fan_drive_1, min_duty_1);
		chk(fan_drive_2, min_duty_2);
		chk(fan_drive_3, min_duty_3);
		u_host.wr(8'h62, 8'h00);
		tick(3);
		chk(fan_drive_1 | fan_drive_2 | fan_drive_3, 8'h00);
		{auto_mode, calc_duty_1} = {1'b0, 8'h44};
		tick(3);
		chk(fan_drive_1, 8'h44);
		chk(fan_drive_2, calc_duty_2);
		$display("floor test done");
	endtask
	// every rate code: first move from 0 toward 0x90 is one step
	task automatic t_ramp;
		logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
		int n;
		for (int c = 0; c < 8; c++) begin
			calc_duty_1 = 8'h00;
			tick(4);
			u_host.wr(8'h62, 8'h08 | 8'(c));
			calc_duty_1 = 8'h90;
			for (n = 0; n < 20 && fan_drive_1 === 8'h00; n++) tick(1);
			chk(fan_drive_1, steps[c]);
			u_host.wr(8'h62, 8'h00);
		end
		$display("ramp test done");
	endtask
	// locked writes are dropped, even once the lock input falls; unmapped reads give zero
	task automatic t_lock;
		tick(1);
		u_host.wr(8'h62, 8'h5a);
		tick(1);
		cfg_lock = 1'b1;
		u_host.wr(8'h62, 8'hff);
		u_host.rd(8'h62, rd_val);
		chk(rd_val, 8'h5a);
		cfg_lock = 1'b0;
		u_host.wr(8'h62, 8'ha5);
		u_host.rd(8'h62, rd_val);
		chk(rd_val, 8'h5a);
		tick(1);
		u_host.rd(8'h63, rd_val);
		chk(rd_val, 8'h00);
		$display("lock test done");
	endtask
	// mid-run reset clears the register and the sticky lock
	task automatic t_reset;
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		u_host.rd(8'h62, rd_val);
		chk(rd_val, 8'h00);
		chk({4'h0, speed_align}, 8'h0c);
		u_host.wr(8'h62, 8'h33);
		u_host.rd(8'h62, rd_val);
		chk(rd_val, 8'h33);
		$display("reset test done");
	endtask
	// hang guard: whole run needs well under 1000 cycles
	always @(posedge clk_sys) if (++cycles == 3000) begin
		mismatches++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		t_reg();
		t_floor();
		t_ramp();
		t_lock();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
